// File: common/lcdhw_defs.vh
// Purpose: constants for the lcd host write interface
// Assumes: ref_clk at 25 MHz, all pin inputs asynchronous
// Notes:   included by the rtl files of this block
//
// Contract
// - interface select high takes parallel transfers, low takes serial ones
// - reset edge direction picks 68 enable or 80 write strobe timing
// - with width select low each parallel byte arrives as two nibbles
// - serial path is 8-bit shifter plus 3-bit counter, only when selected
// - chip deselect clears shifter and counter
// - serial bits arrive msb first, sampled on serial clock rise
// - eighth serial clock rise delivers the assembled byte
// - command/data select sampled at every eighth serial clock rise
// - parallel write with select high goes to display ram path
// - parallel write with select low loads the command register
// - deselected device ignores bus, select, strobe and serial pins
// - reset acts regardless of chip select and starts initialization
// - 80 mode captures the bus on write strobe rise
// - width select high is 8-bit, low is 4-bit parallel
`ifndef LCDHW_DEFS_VH
`define LCDHW_DEFS_VH

`define LCDHW_CLK_HZ        25000000
`define LCDHW_BYTE_W        8
`define LCDHW_NIB_W         4
`define LCDHW_BITCNT_W      3
`define LCDHW_SYNC_W        3
`define LCDHW_HI_NIB_MSB    7
`define LCDHW_HI_NIB_LSB    4
`define LCDHW_INIT_NS       1000
// 1000 ns in 40 ns cycles, rounded up, sized for the 5-bit init counter
`define LCDHW_INIT_CYC      5'h19
`define LCDHW_MODE_80       1'b0
`define LCDHW_MODE_68       1'b1

`endif

// File: rtl/lcdhw_host_if.v
// Purpose: write-only host port of a character lcd controller
// Assumes: all pins asynchronous, ref_clk 25 MHz, nrst synchronous low
// Notes:   delivers whole bytes as one-cycle pulses with a data/command flag
`timescale 1ns/1ps
`include "lcdhw_defs.vh"
module lcdhw_host_if (
   input  wire       ref_clk,
   input  wire       nrst,
   input  wire       par_ser_sel,
   input  wire       bus_width_sel,
   input  wire       reset_polarity_in,
   input  wire       chip_sel_n,
   input  wire       cmd_data_select,
   input  wire       wr_strobe,
   input  wire [7:0] parallel_bus,
   output reg        byte_valid_q,
   output reg  [7:0] byte_data_q,
   output reg        byte_is_data_q,
   output reg        init_q,
   output reg        mode_68_q,
   output reg        half_pending_q
);
   // sync order: bus[7:0], strobe, a/d select, cs_n, res, ifsel, psel
   wire [13:0] raw = {par_ser_sel, bus_width_sel, reset_polarity_in,
                      chip_sel_n, cmd_data_select, wr_strobe,
                      parallel_bus};
   wire [13:0] lvl;
   wire [13:0] rise;
   wire [13:0] fall;

   lcdhw_sync #(
      .W (14)
   ) u_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .pin_in  (raw),
      .level_q (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   wire [7:0] bus_s    = lvl[7:0];
   wire       ad_s     = lvl[9];
   wire       cs_n_s   = lvl[10];
   wire       res_s    = lvl[11];
   wire       wide_s   = lvl[12];
   wire       par_s    = lvl[13];
   wire       stb_rise = rise[8];
   wire       stb_fall = fall[8];
   wire       res_rise = rise[11];
   wire       res_fall = fall[11];

   // serial clock and data share the two top bus pins
   wire       sdat     = bus_s[7];
   wire       sclk_rise = rise[6];

   localparam [4:0] INIT_CYC = `LCDHW_INIT_CYC;

   reg [4:0]  init_cnt_q;
   reg        init_arm_q;
   reg [7:0]  shift_q;
   reg [2:0]  bit_cnt_q;
   reg [3:0]  hi_nib_q;

   wire selected = ~cs_n_s;
   wire par_strobe = mode_68_q ? stb_fall : stb_rise;

   // reset edge seen on the pin, active regardless of chip select
   wire res_edge = res_rise | res_fall;

   always @(posedge ref_clk) begin
      if (!nrst) begin
         init_q     <= 1'b1;
         init_arm_q <= 1'b1;
         init_cnt_q <= 5'h00;
         mode_68_q  <= `LCDHW_MODE_80;
      end else if (res_edge) begin
         init_q     <= 1'b1;
         init_arm_q <= 1'b1;
         init_cnt_q <= 5'h00;
      end else if (init_arm_q) begin
         // level after the edge picks the strobe style
         mode_68_q <= res_s;
         if (init_cnt_q >= INIT_CYC - 5'h01) begin
            init_q     <= 1'b0;
            init_arm_q <= 1'b0;
         end else begin
            init_cnt_q <= init_cnt_q + 5'h01;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (!nrst) begin
         byte_valid_q   <= 1'b0;
         byte_data_q    <= 8'h00;
         byte_is_data_q <= 1'b0;
         half_pending_q <= 1'b0;
         hi_nib_q       <= 4'h0;
         shift_q        <= 8'h00;
         bit_cnt_q      <= 3'h0;
      end else begin
         byte_valid_q <= 1'b0;
         if (init_q) begin
            half_pending_q <= 1'b0;
            shift_q        <= 8'h00;
            bit_cnt_q      <= 3'h0;
         end else if (!selected) begin
            // deselect drops all traffic and clears serial state
            half_pending_q <= 1'b0;
            shift_q        <= 8'h00;
            bit_cnt_q      <= 3'h0;
         end else if (par_s) begin
            // parallel path
            shift_q   <= 8'h00;
            bit_cnt_q <= 3'h0;
            // 68 fall / 80 rise of the strobe
            if (par_strobe) begin
               if (wide_s) begin
                  byte_valid_q   <= 1'b1;
                  byte_data_q    <= bus_s;
                  byte_is_data_q <= ad_s;
               end else if (!half_pending_q) begin
                  // upper nibble first on the upper bus half
                  hi_nib_q       <= bus_s[`LCDHW_HI_NIB_MSB:`LCDHW_HI_NIB_LSB];
                  half_pending_q <= 1'b1;
               end else begin
                  byte_valid_q   <= 1'b1;
                  byte_data_q    <= {hi_nib_q,
                     bus_s[`LCDHW_HI_NIB_MSB:`LCDHW_HI_NIB_LSB]};
                  byte_is_data_q <= ad_s;
                  half_pending_q <= 1'b0;
               end
            end
         end else begin
            // serial path, msb first on serial clock rise
            half_pending_q <= 1'b0;
            if (sclk_rise) begin
               shift_q   <= {shift_q[6:0], sdat};
               bit_cnt_q <= bit_cnt_q + 3'h1;
               if (bit_cnt_q == 3'h7) begin
                  byte_valid_q   <= 1'b1;
                  byte_data_q    <= {shift_q[6:0], sdat};
                  byte_is_data_q <= ad_s;
               end
            end
         end
      end
   end
endmodule // lcdhw_host_if

// File: rtl/lcdhw_sync.v
// Purpose: three-stage pin synchroniser with edge agreement
// Assumes: input asynchronous to ref_clk
// Notes:   stage one feeds stage two only
`timescale 1ns/1ps
`include "lcdhw_defs.vh"
module lcdhw_sync #(
   parameter W = 1
) (
   input  wire         ref_clk,
   input  wire         nrst,
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] level_q,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   always @(posedge ref_clk) begin
      if (!nrst) begin
         s1_q    <= {W{1'b0}};
         s2_q    <= {W{1'b0}};
         s3_q    <= {W{1'b0}};
         level_q <= {W{1'b0}};
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a change counts once stages two and three agree
         if (s2_q == s3_q)
            level_q <= s3_q;
      end
   end

   assign rise = (s2_q == s3_q) ? (s3_q & ~level_q) : {W{1'b0}};
   assign fall = (s2_q == s3_q) ? (~s3_q & level_q) : {W{1'b0}};
endmodule // lcdhw_sync

// File: verif/lcdhw_host_if_sva.sv
// Purpose: port checks for lcdhw_host_if
// Assumes: one clock domain, ref_clk
// Notes:   bound to every instance of the port
`timescale 1ns/1ps
module lcdhw_chk (
   input wire       ref_clk,
   input wire       nrst,
   input wire       reset_polarity_in,
   input wire       chip_sel_n,
   input wire       byte_valid_q,
   input wire [7:0] byte_data_q,
   input wire       init_q,
   input wire       mode_68_q,
   input wire       half_pending_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_one_pulse: assert property (byte_valid_q |=> !byte_valid_q)
      else $error("valid pulse too long");
   a_cs_blocks: assert property (chip_sel_n [*6] |-> !byte_valid_q)
      else $error("byte while deselected");
   a_cs_clears: assert property (chip_sel_n [*6] |-> !half_pending_q)
      else $error("nibble kept while deselected");
   a_init_quiet: assert property (init_q [*6] |-> !byte_valid_q)
      else $error("byte during init");
   a_init_len: assert property (
      $rose(nrst) |-> init_q [*8] ##[10:24] !init_q) else $error("init length");
   a_mode_level: assert property ($fell(init_q) |->
      mode_68_q == reset_polarity_in) else $error("timing mode");
   a_data_hold: assert property (!byte_valid_q |-> $stable(byte_data_q))
      else $error("byte changed without valid");
   a_whole_byte: assert property (byte_valid_q |-> !half_pending_q)
      else $error("byte with half pending");
   c_half: cover property ($rose(half_pending_q));
   c_m68: cover property (byte_valid_q && mode_68_q);
   c_m80: cover property (byte_valid_q && !mode_68_q);
endmodule // lcdhw_chk
bind lcdhw_host_if lcdhw_chk u_chk (.*);

// File: verif/lcdhw_host_mdl.sv
// Purpose: host cpu model writing command and data bytes
// Assumes: each pin level held at least 2 ref_clk, so sync stages two and three agree
// Notes:   released pins invert so no stale value lingers
`timescale 1ns/1ps
module lcdhw_host_mdl (
   input  wire       ref_clk,
   input  wire       m68,
   output reg        chip_sel_n = 1'b1,
   output reg        cmd_data_select = 1'b0,
   output reg        wr_strobe = 1'b1,
   output reg  [7:0] parallel_bus = 8'h00
);
   task strobe(input [7:0] v);
      // leading edge sees the inverse, so only the capture edge finds v
      parallel_bus <= ~v;
      wr_strobe <= m68;
      repeat (2) @(posedge ref_clk);
      parallel_bus <= v;
      repeat (2) @(posedge ref_clk);
      wr_strobe <= ~m68; // capture edge
      repeat (4) @(posedge ref_clk);
   endtask
   task par(input [7:0] b, input ad, input cs, input nib);
      chip_sel_n <= ~cs;
      cmd_data_select <= ad;
      if (nib) strobe({b[7:4], ~b[3:0]});
      strobe(nib ? {b[3:0], b[7:4]} : b);
      chip_sel_n <= 1'b1;
      cmd_data_select <= ~ad;
      parallel_bus <= ~parallel_bus;
      repeat (4) @(posedge ref_clk);
   endtask
   task ser(input [7:0] b, input ad, input cs, input integer n);
      chip_sel_n <= ~cs;
      cmd_data_select <= ad;
      for (int i = 7; i > 7 - n; i--) begin
         parallel_bus[7:6] <= {b[i], 1'b0};
         repeat (4) @(posedge ref_clk);
         parallel_bus[6] <= 1'b1;
         repeat (4) @(posedge ref_clk);
      end
      parallel_bus[7:6] <= {~parallel_bus[7], 1'b0};
      repeat (4) @(posedge ref_clk);
      chip_sel_n <= 1'b1;
      cmd_data_select <= ~ad;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule // lcdhw_host_mdl

// File: verif/test_lcd_host_write_interface.sv
// Purpose: bench for lcdhw_host_if
// Assumes: 40 ns clock, 320 ns strobe and serial period
// Notes:   bytes matched in order against a queue of notes
`timescale 1ns/1ps
module test_lcd_host_write_interface;
   reg        ref_clk = 1'b0;
   reg        nrst = 1'b0;
   reg        par_ser_sel = 1'b1;
   reg        bus_width_sel = 1'b1;
   reg        reset_polarity_in = 1'b0;
   wire       chip_sel_n, cmd_data_select, wr_strobe, byte_valid_q;
   wire       byte_is_data_q, init_q, mode_68_q, half_pending_q;
   wire [7:0] parallel_bus, byte_data_q;
   integer    error_cnt = 0;
   integer    tests_run = 0;
   reg  [8:0] exp_q[$];
   reg  [7:0] b;
   always #20 ref_clk = ~ref_clk;
   lcdhw_host_mdl HM (.ref_clk, .m68(reset_polarity_in), .chip_sel_n,
      .cmd_data_select, .wr_strobe, .parallel_bus);
   lcdhw_host_if DUT (.ref_clk, .nrst, .par_ser_sel, .bus_width_sel,
      .reset_polarity_in, .chip_sel_n, .cmd_data_select, .wr_strobe,
      .parallel_bus, .byte_valid_q, .byte_data_q, .byte_is_data_q,
      .init_q, .mode_68_q, .half_pending_q);
   task chk(input [8:0] got, input [8:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("mismatches %0d of %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // a byte with no note left is refused traffic leaking through
   always @(negedge ref_clk) if (byte_valid_q === 1'b1) begin
      chk({byte_is_data_q, byte_data_q}, exp_q.size() ? exp_q.pop_front() : 'x);
   end
   initial begin
      void'($urandom(32'hBC3B));
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         if (i == 8) reset_polarity_in <= 1'b1;
         repeat (40) @(posedge ref_clk);
         chk({8'h00, mode_68_q}, {8'h00, i[3]});
         bus_width_sel <= ~i[2];
         b = 8'($urandom);
         if (!i[0]) exp_q.push_back({i[1], b});
         HM.par(b, i[1], !i[0], i[2]);
      end
      par_ser_sel <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         b = 8'($urandom);
         // i 2 cuts a frame short, i 4 clocks a full frame deselected
         if (i != 2 && i != 4) exp_q.push_back({i[0], b});
         HM.ser(b, i[0], i != 4, i == 2 ? 5 : 8);
      end
      nrst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({8'h00, init_q}, 9'h001);
      nrst <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk(9'(exp_q.size()), 9'h000);
      end_sim;
   end
   // run needs about 1360 cycles, limit is many times that
   initial begin
      #1000000;
      error_cnt++;
      end_sim;
   end
endmodule // test_lcd_host_write_interface
